// File: rtl/offset_irq_top.sv
// offset correction and two-pin interrupt control with apb registers
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module offset_irq_top
    import irq_offset_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // time base ticks and event sources
    input  wire tick_t       time_tick,
    input  wire src_t        src_event,
    input  wire src_t        src_flag,
    // pin functions from the pin io configuration
    input  wire logic [1:0]  first_irq_pin_function,
    input  wire logic [1:0]  stamp_pin_function,
    // pins
    output logic             irq_out_first_o,
    output logic             irq_out_first_oe,
    output logic             irq_out_second_o,
    output logic             irq_out_second_oe,
    output logic             any_flag_monitor,
    output logic             corr_pulse,
    output logic             corr_sub
);

    // =================================================================
    // register file
    logic [7:0] offset_reg;
    logic [7:0] osc_reg;
    logic [7:0] en_a_reg;
    logic [7:0] en_b_reg;
    logic       stamp_pin_on_reg;

    logic [7:0] word_idx;
    logic       aligned;
    logic       setup_phase;
    logic       wr_fire;
    logic       wr_byte0;

    logic       corr_busy;
    logic [7:0] corr_left;
    logic       corr_pulse_int;
    logic       a_assert;
    logic       b_assert;
    logic       b_assert_n;
    logic       pin_a_on;
    logic       pin_b_on;
    logic       correction_rate_select;
    src_t       ev_all;

    // word index from byte address
    assign word_idx    = paddr[9:2];
    assign aligned     = paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
    assign setup_phase = psel && !penable;
    // writes land only on the access edge that sees pready
    assign wr_fire     = psel && penable && pready && pwrite;
    assign wr_byte0    = wr_fire && pstrb[0] && aligned;

    // decode of mapped indices, used only for the error response
    function automatic logic mapped(input logic [7:0] idx);
        mapped = idx == IDX_OFFSET || idx == IDX_OSC ||
                 idx == IDX_EN_A   || idx == IDX_EN_B ||
                 idx == IDX_STATUS;
    endfunction

    // read value of one index; unmapped words read zero
    function automatic logic [31:0] read_word(
        input logic [7:0] idx,
        input logic [7:0] offv,
        input logic [7:0] oscv,
        input logic [7:0] env_a,
        input logic [7:0] env_b,
        input logic [15:0] stat
    );
        case (idx)
            IDX_OFFSET: read_word = {24'h000000, offv};
            IDX_OSC:    read_word = {24'h000000, oscv};
            IDX_EN_A:   read_word = {24'h000000, env_a};
            IDX_EN_B:   read_word = {24'h000000, env_b};
            IDX_STATUS: read_word = {16'h0000, stat};
            default:    read_word = 32'h00000000;
        endcase
    endfunction

    // =================================================================
    // apb handshake: one wait-free access phase per transfer
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= !(aligned && mapped(word_idx));
            // status is sampled here, one cycle before the read ends
            prdata  <= pwrite ? 32'h00000000
                     : read_word(word_idx, offset_reg, osc_reg,
                                 en_a_reg, en_b_reg,
                                 {corr_busy, corr_left,
                                  any_flag_monitor, 2'h0,
                                  b_assert, a_assert,
                                  pin_b_on, pin_a_on});
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // offset value, taken by the corrector at its trigger
    always_ff @(posedge clk) begin
        if (srst) begin
            offset_reg <= REG_RESET;
        end else if (wr_byte0 && word_idx == IDX_OFFSET) begin
            offset_reg <= pwdata[7:0];
        end
    end

    // oscillator control, only the rate bit steers this block
    always_ff @(posedge clk) begin
        if (srst) begin
            osc_reg <= REG_RESET;
        end else if (wr_byte0 && word_idx == IDX_OSC) begin
            osc_reg <= pwdata[7:0];
        end
    end

    // first pin enable register
    always_ff @(posedge clk) begin
        if (srst) begin
            en_a_reg <= REG_RESET;
        end else if (wr_byte0 && word_idx == IDX_EN_A) begin
            en_a_reg <= pwdata[7:0];
        end
    end

    // second pin enable register
    always_ff @(posedge clk) begin
        if (srst) begin
            en_b_reg <= REG_RESET;
        end else if (wr_byte0 && word_idx == IDX_EN_B) begin
            en_b_reg <= pwdata[7:0];
        end
    end

    assign correction_rate_select = osc_reg[RATE_BIT];

    // =================================================================
    // correction scheduler
    offset_corrector u_corr (
        .clk        (clk),
        .srst       (srst),
        .rate_fast  (correction_rate_select),
        .offset     (offset_reg),
        .tick       (time_tick),
        .corr_pulse (corr_pulse_int),
        .corr_sub   (corr_sub),
        .busy       (corr_busy),
        .left       (corr_left)
    );

    assign corr_pulse = corr_pulse_int;

    // correction pulse replaces any outside offset event line
    always_comb begin
        ev_all        = src_event;
        ev_all.offset = corr_pulse_int;
    end

    // =================================================================
    // pin function decode
    assign pin_a_on = first_irq_pin_function == PIN_FN_IRQ;
    assign pin_b_on = stamp_pin_function == PIN_FN_IRQ;

    // both pins get the same sources, their own enables
    irq_pin_gen u_pin_a (
        .clk          (clk),
        .srst         (srst),
        .enable       (en_a_reg),
        .event_in     (ev_all),
        .flag_in      (src_flag),
        .hz128        (time_tick.hz128),
        .pin_on       (pin_a_on),
        .assert_reg   (a_assert),
        .assert_n_reg ()
    );

    irq_pin_gen u_pin_b (
        .clk          (clk),
        .srst         (srst),
        .enable       (en_b_reg),
        .event_in     (ev_all),
        .flag_in      (src_flag),
        .hz128        (time_tick.hz128),
        .pin_on       (pin_b_on),
        .assert_reg   (b_assert),
        .assert_n_reg (b_assert_n)
    );

    // =================================================================
    // pin drivers
    // open drain: the data line never goes high, only the enable moves
    assign irq_out_first_o  = 1'b0;
    assign irq_out_first_oe = a_assert;

    // push-pull on the stamp pin, enable follows the pin function
    always_ff @(posedge clk) begin
        if (srst) begin
            stamp_pin_on_reg <= 1'b0;
        end else begin
            stamp_pin_on_reg <= pin_b_on;
        end
    end

    assign irq_out_second_o  = b_assert_n;
    assign irq_out_second_oe = stamp_pin_on_reg;

    // monitor of all flags, enabled or not
    always_ff @(posedge clk) begin
        if (srst) begin
            any_flag_monitor <= 1'b0;
        end else begin
            any_flag_monitor <= |src_flag;
        end
    end

    // =================================================================
    // checks
    property p_monitor;
        @(posedge clk) disable iff (srst)
        ##1 any_flag_monitor == $past(|src_flag);
    endproperty
    a_monitor: assert property (p_monitor)
        else $error("monitor does not follow the flags");

    property p_enable_reset;
        @(posedge clk)
        srst |=> en_a_reg == 8'h00 && en_b_reg == 8'h00;
    endproperty
    a_enable_reset: assert property (p_enable_reset)
        else $error("enable registers not zero after reset");

    property p_pins_apart;
        @(posedge clk) disable iff (srst)
        pin_a_on && pin_b_on && en_b_reg == 8'h00
            |=> !irq_out_second_oe || irq_out_second_o;
    endproperty
    a_pins_apart: assert property (p_pins_apart)
        else $error("second pin asserted with no source enabled");

    property p_offset_irq;
        @(posedge clk) disable iff (srst)
        corr_pulse_int && pin_a_on && en_a_reg[5] && !en_a_reg[LP_BIT]
            |=> irq_out_first_oe;
    endproperty
    a_offset_irq: assert property (p_offset_irq)
        else $error("correction pulse gave no first pin interrupt");

    property p_apb_answer;
        @(posedge clk) disable iff (srst)
        setup_phase |=> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb access phase without ready");

endmodule

// File: rtl/irq_offset_pkg.sv
// constants, types and helpers for offset correction and interrupt pins
// =====================================================================
// Function
// - normal rate starts correction every four hours, one pulse per minute
// - normal rate pulses at minutes 00..n-1, overflow runs into next hours
// - value -128 normal: two full hours then minutes 00 to 07
// - fast rate starts correction every eight minutes, one pulse per second
// - fast rate pulses at seconds 00..n-1, overflow into next minutes
// - correction enable gives one interrupt pulse per correction pulse, in pulse mode only; level mode gives none
// - two independent interrupt pins, each with its own enable register
// - first pin is open drain, gated by its two-bit pin function
// - second pin is push-pull on stamp pin when its function selects it
// - pins drive only when configured for interrupts, active low
// - enable bit 7 level/pulse, bits 6..0 sources, reset zero
// - mode bit 0 gives pulses, 1 gives a level following flags
// - pulse mode fires on each trigger of an enabled source
// - pulse starts with event, released by 128 Hz tick, one to two periods
// - clearing the source flag ends the pulse early
// - level mode asserts while any enabled flag is set
// - monitor bit shows OR of all flags, enabled or not
// - rate select bit 6 of oscillator register, 0 normal by default
// - offset is 8-bit two's complement, sign selects add or remove
// - correction adds or removes clock pulses, oscillator untouched
package irq_offset_pkg;

    // =================================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_OFFSET = 8'h24;
    localparam logic [7:0] IDX_OSC    = 8'h25;
    localparam logic [7:0] IDX_EN_A   = 8'h29;
    localparam logic [7:0] IDX_EN_B   = 8'h2a;
    localparam logic [7:0] IDX_STATUS = 8'h30;

    localparam int         LP_BIT       = 7;
    localparam int         RATE_BIT     = 6;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [2:0] NORMAL_HOURS = 3'h4;
    localparam logic [3:0] FAST_MINUTES = 4'h8;
    localparam logic [1:0] PIN_FN_IRQ   = 2'h2;
    // offset correction has no flag, so only its pulse is kept
    localparam logic [6:0] FLAGGED      = 7'h5f;

    // =================================================================
    // sources in enable-register bit order 6..0
    typedef struct packed {
        logic periodic;
        logic offset;
        logic alarm_one;
        logic alarm_two;
        logic stamp;
        logic supply;
        logic dog;
    } src_t;

    typedef struct packed {
        logic hour;
        logic minute;
        logic second;
        logic hz128;
    } tick_t;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b01,
        CS_RUN  = 2'b10
    } corr_state_t;

    // magnitude of a two's complement byte, -128 gives 8'h80
    function automatic logic [7:0] mag8(input logic [7:0] v);
        mag8 = v[7] ? 8'(~v + 8'h01) : v;
    endfunction

endpackage

// File: rtl/offset_corrector.sv
// correction pulse scheduler for normal and fast rate
`timescale 1ns/10ps
module offset_corrector
    import irq_offset_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       rate_fast,
    input  wire logic [7:0] offset,
    input  wire tick_t      tick,
    output logic            corr_pulse,
    output logic            corr_sub,
    output logic            busy,
    output logic [7:0]      left
);
    corr_state_t state_reg;
    logic [2:0]  period_reg;
    logic        per_tick;
    logic        trig;
    logic        step;

    // period tick is the hour in normal rate, the minute in fast rate
    assign per_tick = rate_fast ? tick.minute : tick.hour;
    assign trig     = per_tick && period_reg == 3'h0;
    assign step     = rate_fast ? tick.second : tick.minute;
    assign busy     = state_reg == CS_RUN;

    // period counter, wraps at four hours or eight minutes
    always_ff @(posedge clk) begin
        if (srst) begin
            period_reg <= 3'h0;
        end else if (per_tick) begin
            if (period_reg == (rate_fast ? 3'(FAST_MINUTES - 4'h1)
                                         : NORMAL_HOURS - 3'h1))
                period_reg <= 3'h0;
            else
                period_reg <= period_reg + 3'h1;
        end
    end

    // first pulse on the trigger itself, then one per step
    // overflow past 60 steps just keeps counting into the next hour or, at fast rate, the next minute
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg  <= CS_IDLE;
            left       <= 8'h00;
            corr_pulse <= 1'b0;
            corr_sub   <= 1'b0;
        end else begin
            corr_pulse <= 1'b0;
            case (state_reg)
                CS_IDLE: begin
                    if (trig && offset != 8'h00) begin
                        corr_pulse <= 1'b1;
                        corr_sub   <= offset[7];
                        left       <= mag8(offset) - 8'h01;
                        if (mag8(offset) != 8'h01)
                            state_reg <= CS_RUN;
                    end
                end
                CS_RUN: begin
                    // new triggers are ignored until done
                    if (step) begin
                        corr_pulse <= 1'b1;
                        left       <= left - 8'h01;
                        if (left == 8'h01)
                            state_reg <= CS_IDLE;
                    end
                end
                default: state_reg <= CS_IDLE;
            endcase
        end
    end

    property p_run_step;
        @(posedge clk) disable iff (srst)
        busy && step |=> corr_pulse;
    endproperty
    a_run_step: assert property (p_run_step)
        else $error("step in run gave no correction pulse");

    property p_hold_latched;
        @(posedge clk) disable iff (srst)
        busy && !step |=> $stable(left) && $stable(corr_sub);
    endproperty
    a_hold_latched: assert property (p_hold_latched)
        else $error("running sequence changed without a step");

    property p_last_pulse;
        @(posedge clk) disable iff (srst)
        corr_pulse && left == 8'h00 |-> state_reg == CS_IDLE;
    endproperty
    a_last_pulse: assert property (p_last_pulse)
        else $error("sequence kept running after last pulse");
endmodule

// File: rtl/irq_pin_gen.sv
// one interrupt pin: pulse stretching, level mode and source OR
`timescale 1ns/10ps
module irq_pin_gen
    import irq_offset_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] enable,
    input  wire src_t       event_in,
    input  wire src_t       flag_in,
    input  wire logic       hz128,
    input  wire logic       pin_on,
    output logic            assert_reg,
    output logic            assert_n_reg
);
    logic [6:0] act_reg;
    logic [6:0] seen_reg;
    logic [6:0] hit;
    logic [6:0] expire;
    logic [6:0] act_next;
    logic       want;

    assign hit    = event_in & enable[6:0];
    // second 128 Hz tick after the event ends the pulse
    assign expire = hz128 ? (act_reg & seen_reg) : 7'h00;
    // a fresh event wins over expiry and over a flag clear
    // a source switched off drops its pending pulse at once
    assign act_next = hit | (act_reg & enable[6:0] & ~expire
                      & ~(~flag_in & FLAGGED));
    // offset has no flag, so its flag bit never holds a level
    assign want = enable[LP_BIT]
                ? |(flag_in & enable[6:0] & FLAGGED)
                : |act_next;

    // per-source pulse state
    always_ff @(posedge clk) begin
        if (srst) begin
            act_reg  <= 7'h00;
            seen_reg <= 7'h00;
        end else begin
            act_reg  <= act_next;
            seen_reg <= act_next & ~hit & (hz128 ? 7'h7f : seen_reg);
        end
    end

    // pin level, held off unless the pin function selects interrupts
    always_ff @(posedge clk) begin
        if (srst) begin
            assert_reg   <= 1'b0;
            assert_n_reg <= 1'b1;
        end else begin
            assert_reg   <= pin_on && want;
            assert_n_reg <= !(pin_on && want);
        end
    end

    property p_level;
        @(posedge clk) disable iff (srst)
        pin_on && enable[LP_BIT] && |(flag_in & enable[6:0] & FLAGGED)
            |=> assert_reg && !assert_n_reg;
    endproperty
    a_level: assert property (p_level)
        else $error("level mode pin not asserted with enabled flag");

    property p_pulse;
        @(posedge clk) disable iff (srst)
        pin_on && !enable[LP_BIT] && |hit |=> assert_reg [*1];
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("enabled event gave no pulse");

    property p_off;
        @(posedge clk) disable iff (srst)
        !pin_on |=> !assert_reg && assert_n_reg;
    endproperty
    a_off: assert property (p_off)
        else $error("pin driven while not configured");

    property p_offset_end;
        @(posedge clk) disable iff (srst)
        $fell(act_reg[5]) |-> $past(hz128) && $past(seen_reg[5]);
    endproperty
    a_offset_end: assert property (p_offset_end)
        else $error("offset pulse ended off the 128 Hz tick");
endmodule

// File: testbench/irq_host_model.sv
// host side model of the two interrupt input lines
`timescale 1ns/10ps
module irq_host_model (
    input  wire logic clk,
    input  wire logic first_o,
    input  wire logic first_oe,
    input  wire logic second_o,
    input  wire logic second_oe,
    output logic      line_a,
    output logic      line_b
);
    logic last_b = 1'b0;
    // ==========================================================
    // open drain line with a board pull-up, released reads high
    assign line_a = first_oe ? first_o : 1'b1;
    // undriven push-pull line shows the inverse of its last level
    // so a stale copy can never pass for a driven one
    assign line_b = second_oe ? second_o : ~last_b;
    always_ff @(posedge clk) begin
        if (second_oe) begin
            last_b <= second_o;
        end
    end
endmodule

// File: testbench/offset_correction_and_interrupt_control_tb.sv
// self-checking bench for correction scheduling and interrupt pins
`timescale 1ns/10ps
module offset_correction_and_interrupt_control_tb;
    import irq_offset_pkg::*;
    typedef struct packed {
        logic [7:0] ea;
        logic [7:0] eb;
        logic [6:0] ev;
        logic [6:0] fl;
        logic       a;
        logic       b;
    } row_t;
    logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'h1;
    logic        pready, pslverr, er;
    tick_t       time_tick = '0;
    src_t        src_event = '0, src_flag = '0;
    logic [1:0]  fn_a = 2'h2, fn_s = 2'h2;
    logic        oa, oea, ob, oeb, mon, cp, cs, line_a, line_b;
    int          fail_count = 0, compares = 0, cyc = 0, pc = 0, base, i;
    // ea eb event flag -> pin a asserted, pin b asserted
    row_t rows [8] = '{
        '{8'h01, 8'h00, 7'h01, 7'h01, 1'b1, 1'b0},
        '{8'h00, 8'h40, 7'h40, 7'h40, 1'b0, 1'b1},
        '{8'h10, 8'h08, 7'h08, 7'h08, 1'b0, 1'b1},
        '{8'h10, 8'h00, 7'h10, 7'h10, 1'b1, 1'b0},
        '{8'h04, 8'h00, 7'h04, 7'h04, 1'b1, 1'b0},
        '{8'h02, 8'h02, 7'h02, 7'h02, 1'b1, 1'b1},
        '{8'h81, 8'h00, 7'h00, 7'h01, 1'b1, 1'b0},
        '{8'h81, 8'h82, 7'h00, 7'h12, 1'b0, 1'b1}
    };
    offset_irq_top i_offset_irq_top (.clk(clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .time_tick(time_tick), .src_event(src_event), .src_flag(src_flag),
        .first_irq_pin_function(fn_a), .stamp_pin_function(fn_s),
        .irq_out_first_o(oa), .irq_out_first_oe(oea),
        .irq_out_second_o(ob), .irq_out_second_oe(oeb),
        .any_flag_monitor(mon), .corr_pulse(cp), .corr_sub(cs));
    irq_host_model i_irq_host_model (.clk(clk), .first_o(oa),
        .first_oe(oea), .second_o(ob), .second_oe(oeb),
        .line_a(line_a), .line_b(line_b));
    // ==========================================================
    // clock, hang guard well above the roughly 1300 cycles needed
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // correction pulses seen, counted on the edge like the design
    always @(posedge clk) begin
        if (cp === 1'b1) pc <= pc + 1;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        compares++;
        if (seen !== ex) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task stop_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // apb transfer, held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task tk(input logic [3:0] t);
        @(posedge clk);
        time_tick <= tick_t'(t);
        @(posedge clk);
        time_tick <= '0;
        repeat (2) @(posedge clk);
    endtask
    task fire(input logic [6:0] v);
        @(posedge clk);
        src_event <= src_t'(v);
        src_flag <= src_t'(v);
        @(posedge clk);
        src_event <= '0;
        repeat (2) @(posedge clk);
    endtask
    task rst();
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
    endtask
    initial begin
        rst();
        chk("oe b", oeb, 0);
        chk("data b", ob, 1);
        chk("oe a", oea, 0);
        chk("data a", oa, 0);
        apb(0, IDX_EN_A, 0);
        chk("en a", rd, 0);
        chk("err en a", er, 0);
        apb(0, IDX_EN_B, 0);
        chk("en b", rd, 0);
        apb(1, IDX_EN_B, 8'hff);
        apb(0, IDX_EN_B, 0);
        chk("en b rw", rd, 32'hff);
        pstrb <= 4'h0;
        apb(1, IDX_EN_B, 8'h00);
        pstrb <= 4'h1;
        apb(0, IDX_EN_B, 0);
        chk("strobe off", rd, 32'hff);
        apb(0, 8'h01, 0);
        chk("unmapped", er, 1);
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            apb(1, IDX_EN_A, rows[i].ea);
            apb(1, IDX_EN_B, rows[i].eb);
            @(posedge clk);
            src_event <= src_t'(rows[i].ev);
            src_flag <= src_t'(rows[i].fl);
            @(posedge clk);
            src_event <= '0;
            repeat (2) @(posedge clk);
            chk("pin a", !line_a, rows[i].a);
            chk("pin b", !line_b, rows[i].b);
            chk("monitor", mon, |rows[i].fl);
            src_flag <= '0;
            repeat (3) @(posedge clk);
            chk("clear a", !line_a, 0);
            chk("clear b", !line_b, 0);
            $display("test row %0d done", i);
        end
        // pulse with its flag held ends only on the second slow tick
        apb(1, IDX_EN_A, 8'h01);
        fire(7'h01);
        tk(4'h1);
        chk("hold", !line_a, 1);
        tk(4'h1);
        chk("release", !line_a, 0);
        src_flag <= '0;
        // pins left unconfigured must stay undriven
        fn_a <= 2'h1;
        fn_s <= 2'h0;
        apb(1, IDX_EN_B, 8'h01);
        fire(7'h01);
        chk("oe a off", oea, 0);
        chk("oe b off", oeb, 0);
        src_flag <= '0;
        fn_a <= 2'h2;
        fn_s <= 2'h2;
        $display("test pulse width and pin function done");
        rst();
        apb(1, IDX_OFFSET, 8'h01);
        apb(1, IDX_EN_A, 8'h20);
        base = pc;
        tk(4'he);
        chk("corr irq", !line_a, 1);
        repeat (4) tk(4'he);
        chk("normal count", pc - base, 2);
        // most negative value: trigger on the next fourth hour
        apb(1, IDX_OFFSET, 8'h80);
        repeat (4) tk(4'he);
        repeat (128) tk(4'h4);
        chk("normal full", pc - base, 130);
        $display("test normal rate done");
        rst();
        chk("reset a", oea, 0);
        apb(1, IDX_OSC, 8'h40);
        apb(1, IDX_OFFSET, 8'h03);
        base = pc;
        tk(4'h6);
        repeat (3) tk(4'h2);
        chk("fast three", pc - base, 3);
        repeat (7) tk(4'h6);
        chk("fast idle", pc - base, 3);
        apb(1, IDX_OFFSET, 8'h80);
        tk(4'h6);
        apb(1, IDX_OFFSET, 8'h01);
        chk("sub", cs, 1);
        // busy, 127 left, both pins configured, nothing asserted
        apb(0, IDX_STATUS, 0);
        chk("status", rd, 32'h0000bf83);
        repeat (130) tk(4'h2);
        chk("fast full", pc - base, 131);
        $display("test fast rate done");
        stop_test();
    end
endmodule
